// >>> core/tti_tape_ctl.sv
// Purpose: controller end of one tape transport cable, behind a register port
// Assumes: transport keeps motion, density, busy, ready and record status itself
// Notes:   all cable inputs are synchronised; read strobe found by edge detection
//
// The implementer's own choices: the address map and strobed register access.
`timescale 1ns/1ps
module tti_tape_ctl
  import tti_pkg::*;
(
  input  wire logic              mclk_i, // system clock, 100 MHz
  input  wire logic              reset_n_i, // async reset, active low
  // register port
  input  wire logic [ADDR_W-1:0] reg_addr_i, // register byte address
  input  wire logic [DATA_W-1:0] reg_wdata_i, // write data
  input  wire logic              reg_we_i, // write strobe
  input  wire logic              reg_re_i, // read strobe
  output logic      [DATA_W-1:0] reg_rdata_o, // read data, next cycle
  // cable toward the transport
  output logic      [CHAR_W-1:0] write_char_o, // six data bits and parity
  output logic                   write_strobe_o, // 4 us character strobe
  output logic                   fwd_o, // forward motion
  output logic                   rev_o, // reverse motion
  output logic                   search_o, // search to file mark
  output logic                   rewind_o, // rewind to load point
  output logic                   unload_o, // rewind and unload
  output logic                   dens_high_o, // select 556 lpi
  output logic                   dens_low_o, // select 200 lpi
  output logic                   write_sel_o, // write and verify enable
  output logic                   read_start_o, // read enable
  output logic                   initial_condition_clear_o, // clear transport selects
  output logic                   lamp_connect_o, // unit select light 1
  output logic                   lamp_reserve_o, // unit select light 2
  // cable from the transport
  input  wire logic [CHAR_W-1:0] read_char_i, // six data bits and parity
  input  wire logic              read_strobe_i, // read character pulse
  input  wire logic [UNIT_W-1:0] unit_addr_i, // unit select lines
  input  wire logic              ready_i, // ready
  input  wire logic              busy_i, // tape in motion
  input  wire logic              dens556_i, // 556 lpi selected
  input  wire logic              file_mark_i, // file mark seen
  input  wire logic              load_point_i, // at load point
  input  wire logic              end_of_tape_i, // end of tape marker
  input  wire logic              write_enable_i, // ring in, tape loaded
  input  wire logic              dens800_i, // 800 lpi selected
  input  wire logic              end_of_record_i // end of record
);

  typedef enum logic [1:0] {SEQ_IDLE, SEQ_RUN, SEQ_GAP} tti_seq_t;

  typedef struct packed {
    logic [DATA_W-1:0]      rdata;
    tti_motion_t            motion_req;
    tti_motion_t            motion_out;
    tti_seq_t               seq;
    logic [CTRL_DENS_W-1:0] dens;
    logic                   wsel;
    logic                   rstart;
    logic                   lamp1;
    logic                   lamp2;
    logic [CHAR_W-1:0]      wchar;
    logic [CHAR_W-1:0]      rchar;
    logic                   rd_valid;
    logic                   overrun;
    logic                   rstb_q;
    logic [UNIT_IDX_W-1:0]  unit_idx;
    logic                   unit_ok;
  } tti_ctl_state_t;

  tti_ctl_state_t st_r;
  tti_ctl_state_t st_nxt;

  // one line per motion command; unknown codes drive nothing
  function automatic logic [MOTION_LINES-1:0] motion_lines(tti_motion_t m);
    logic [MOTION_LINES-1:0] l;
    l = '0;
    case (m)
      MOT_FWD:    l = 5'h01;
      MOT_REV:    l = 5'h02;
      MOT_SEARCH: l = 5'h04;
      MOT_REWIND: l = 5'h08;
      MOT_UNLOAD: l = 5'h10;
      default:    l = '0;
    endcase
    return l;
  endfunction : motion_lines

  // true when exactly one unit line is high
  function automatic logic unit_onehot(logic [UNIT_W-1:0] v);
    return (v != '0) && ((v & (v - 1'b1)) == '0);
  endfunction : unit_onehot

  // highest set line
  function automatic logic [UNIT_IDX_W-1:0] unit_encode(logic [UNIT_W-1:0] v);
    logic [UNIT_IDX_W-1:0] idx;
    idx = '0;
    for (int i = 0; i < UNIT_W; i++) begin
      if (v[i]) begin
        idx = UNIT_IDX_W'(i);
      end
    end
    return idx;
  endfunction : unit_encode

  // every cable input crosses through two flops first
  logic [SYNC_W-1:0] sync_q;
  logic [CHAR_W-1:0] rchar_s;
  logic              rstb_s;
  logic [UNIT_W-1:0] unit_s;
  logic [STAT_PIN_W-1:0] pins_s;

  tti_sync #(
    .W (SYNC_W)
  ) u_sync (
    .mclk_i    (mclk_i),
    .reset_n_i (reset_n_i),
    .d_i       ({end_of_record_i, dens800_i, write_enable_i, end_of_tape_i,
                 load_point_i, file_mark_i, dens556_i, busy_i, ready_i,
                 unit_addr_i, read_strobe_i, read_char_i}),
    .q_o       (sync_q)
  );

  // synchronised fields
  assign rchar_s = sync_q[CHAR_W-1:0];
  assign rstb_s  = sync_q[CHAR_W];
  assign unit_s  = sync_q[CHAR_W+1 +: UNIT_W];
  assign pins_s  = sync_q[CHAR_W+1+UNIT_W +: STAT_PIN_W];

  // write strobe and clear pulse timers
  tti_pulse_if wr_if ();
  tti_pulse_if clr_if ();

  tti_pulse_gen #(
    .CYCLES (WSTROBE_CYC)
  ) u_wr_strobe (
    .mclk_i    (mclk_i),
    .reset_n_i (reset_n_i),
    .pls       (wr_if.gen)
  );

  tti_pulse_gen #(
    .CYCLES (CLEAR_CYC)
  ) u_clear (
    .mclk_i    (mclk_i),
    .reset_n_i (reset_n_i),
    .pls       (clr_if.gen)
  );

  // address decode
  logic wr_ctrl;
  logic wr_wchar;
  logic wr_clear;
  logic rd_rchar;
  logic rd_rise;

  assign wr_ctrl  = reg_we_i && (reg_addr_i == REG_CTRL) && !clr_if.active;
  assign wr_wchar = reg_we_i && (reg_addr_i == REG_WCHAR) && !wr_if.active;
  assign wr_clear = reg_we_i && (reg_addr_i == REG_CLEAR) && !clr_if.active;
  assign rd_rchar = reg_re_i && (reg_addr_i == REG_RCHAR);
  assign rd_rise  = rstb_s && !st_r.rstb_q;

  // a new character only starts once the previous strobe has ended
  assign wr_if.start  = wr_wchar;
  assign clr_if.start = wr_clear;

  // next state: register writes, motion sequencing, read capture, read mux
  always_comb begin
    st_nxt        = st_r;
    st_nxt.rstb_q = rstb_s;
    // zero unless read
    st_nxt.rdata  = '0;

    if (wr_ctrl) begin
      st_nxt.motion_req = tti_motion_t'(reg_wdata_i[CTRL_MOTION_LSB +: CTRL_MOTION_W]);
      st_nxt.dens       = reg_wdata_i[CTRL_DENS_LSB +: CTRL_DENS_W];
      st_nxt.wsel       = reg_wdata_i[CTRL_WSEL_BIT];
      st_nxt.rstart     = reg_wdata_i[CTRL_RSTART_BIT];
      st_nxt.lamp1      = reg_wdata_i[CTRL_LAMP1_BIT];
      st_nxt.lamp2      = reg_wdata_i[CTRL_LAMP2_BIT];
    end

    // held until next write
    if (wr_wchar) begin
      st_nxt.wchar = reg_wdata_i[CHAR_W-1:0];
    end

    // a changed request first drops the old line for two cycles, gap then idle
    case (st_r.seq)
      SEQ_IDLE: begin
        if (motion_lines(st_r.motion_req) != '0) begin
          st_nxt.motion_out = st_r.motion_req;
          st_nxt.seq        = SEQ_RUN;
        end
      end
      SEQ_RUN: begin
        if (st_r.motion_req != st_r.motion_out) begin
          st_nxt.motion_out = MOT_NONE;
          st_nxt.seq        = SEQ_GAP;
        end
      end
      SEQ_GAP: begin
        st_nxt.seq = SEQ_IDLE;
      end
      default: begin
        st_nxt.motion_out = MOT_NONE;
        st_nxt.seq        = SEQ_IDLE;
      end
    endcase

    // clear drops every select and motion at once; lamps are channel state
    if (wr_clear) begin
      st_nxt.motion_req = MOT_NONE;
      st_nxt.motion_out = MOT_NONE;
      st_nxt.seq        = SEQ_IDLE;
      st_nxt.dens       = '0;
      st_nxt.wsel       = 1'b0;
      st_nxt.rstart     = 1'b0;
    end

    // capture on the strobe edge; data and strobe share the same delay
    if (rd_rchar) begin
      st_nxt.rd_valid = 1'b0;
      st_nxt.overrun  = 1'b0;
    end
    if (rd_rise) begin
      st_nxt.rchar    = rchar_s;
      st_nxt.rd_valid = 1'b1;
      st_nxt.overrun  = st_r.rd_valid && !rd_rchar;
    end

    // the unit number follows only a clean one-hot pattern
    if (unit_onehot(unit_s)) begin
      st_nxt.unit_idx = unit_encode(unit_s);
      st_nxt.unit_ok  = 1'b1;
    end else if (unit_s == '0) begin
      st_nxt.unit_ok  = st_r.unit_ok;
    end

    // data stand one cycle only
    if (reg_re_i) begin
      case (reg_addr_i)
        REG_CTRL: begin
          st_nxt.rdata[CTRL_MOTION_LSB +: CTRL_MOTION_W] = st_r.motion_req;
          st_nxt.rdata[CTRL_DENS_LSB +: CTRL_DENS_W]     = st_r.dens;
          st_nxt.rdata[CTRL_WSEL_BIT]                    = st_r.wsel;
          st_nxt.rdata[CTRL_RSTART_BIT]                  = st_r.rstart;
          st_nxt.rdata[CTRL_LAMP1_BIT]                   = st_r.lamp1;
          st_nxt.rdata[CTRL_LAMP2_BIT]                   = st_r.lamp2;
        end
        REG_WCHAR: begin
          st_nxt.rdata[CHAR_W-1:0] = st_r.wchar;
        end
        REG_RCHAR: begin
          st_nxt.rdata[CHAR_W-1:0] = st_r.rchar;
        end
        REG_STATUS: begin
          st_nxt.rdata[STAT_PIN_W-1:0] = pins_s;
          st_nxt.rdata[ST_RD_VALID]    = st_r.rd_valid;
          st_nxt.rdata[ST_OVERRUN]     = st_r.overrun;
          st_nxt.rdata[ST_WR_BUSY]     = wr_if.active;
          st_nxt.rdata[ST_UNIT_OK]     = st_r.unit_ok;
          st_nxt.rdata[ST_UNIT_LSB +: UNIT_IDX_W] = st_r.unit_idx;
        end
        default: begin
          st_nxt.rdata = '0;
        end
      endcase
    end
  end

  // one state register
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st_r            <= '0;
      st_r.motion_req <= tti_motion_t'(CTRL_RESET[CTRL_MOTION_LSB +: CTRL_MOTION_W]);
      st_r.motion_out <= MOT_NONE;
      st_r.seq        <= SEQ_IDLE;
    end else begin
      st_r <= st_nxt;
    end
  end

  // cable outputs, all from registers except the decoded motion and density lines
  logic [MOTION_LINES-1:0] mot_l;
  assign mot_l = motion_lines(st_r.motion_out);

  assign reg_rdata_o               = st_r.rdata;
  assign write_char_o              = st_r.wchar;
  assign write_strobe_o            = wr_if.active;
  assign fwd_o                     = mot_l[0];
  assign rev_o                     = mot_l[1];
  assign search_o                  = mot_l[2];
  assign rewind_o                  = mot_l[3];
  assign unload_o                  = mot_l[4];
  assign dens_high_o               = (st_r.dens == DENS_HIGH);
  assign dens_low_o                = (st_r.dens == DENS_LOW);
  assign write_sel_o               = st_r.wsel;
  assign read_start_o              = st_r.rstart;
  assign initial_condition_clear_o = clr_if.active;
  assign lamp_connect_o            = st_r.lamp1;
  assign lamp_reserve_o            = st_r.lamp2;

endmodule : tti_tape_ctl

// >>> core/tti_pkg.sv
// Purpose: shared constants and types for the tape transport interface controller
// Assumes: 100 MHz mclk_i, plain register port with 8-bit address and 16-bit data
// Notes:   all offsets, field positions, reset values and timing counts live here
//
// How it works
// - seven write lines: six data, one parity
// - 4 us write strobe per character
// - all-zero unit address tolerated, no misselect
// - lamp one shows unit is connected
// - lamp two shows unit is reserved
// - read strobe pulse samples seven read lines
package tti_pkg;

  // register port geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;

  // register offsets
  localparam logic [ADDR_W-1:0] REG_CTRL   = 8'h00;
  localparam logic [ADDR_W-1:0] REG_WCHAR  = 8'h04;
  localparam logic [ADDR_W-1:0] REG_RCHAR  = 8'h08;
  localparam logic [ADDR_W-1:0] REG_STATUS = 8'h0C;
  localparam logic [ADDR_W-1:0] REG_CLEAR  = 8'h10;

  // control register fields
  localparam int CTRL_MOTION_LSB = 0;
  localparam int CTRL_MOTION_W   = 3;
  localparam int CTRL_DENS_LSB   = 3;
  localparam int CTRL_DENS_W     = 2;
  localparam int CTRL_WSEL_BIT   = 5;
  localparam int CTRL_RSTART_BIT = 6;
  localparam int CTRL_LAMP1_BIT  = 7;
  localparam int CTRL_LAMP2_BIT  = 8;
  localparam logic [DATA_W-1:0] CTRL_RESET = 16'h0000;

  // character and pin widths
  localparam int CHAR_W     = 7;
  localparam int PARITY_BIT = 6;
  localparam int UNIT_W     = 8;
  localparam int UNIT_IDX_W = 3;
  localparam int STAT_PIN_W = 9;
  localparam int SYNC_W     = CHAR_W + 1 + UNIT_W + STAT_PIN_W;

  // status register bit positions; low nine mirror the pins
  localparam int ST_READY     = 0;
  localparam int ST_BUSY      = 1;
  localparam int ST_DENS556   = 2;
  localparam int ST_FILE_MARK = 3;
  localparam int ST_LOAD_PT   = 4;
  localparam int ST_END_TAPE  = 5;
  localparam int ST_WR_ENABLE = 6;
  localparam int ST_DENS800   = 7;
  localparam int ST_END_REC   = 8;
  localparam int ST_RD_VALID  = 9;
  localparam int ST_OVERRUN   = 10;
  localparam int ST_WR_BUSY   = 11;
  localparam int ST_UNIT_OK   = 12;
  localparam int ST_UNIT_LSB  = 13;

  // motion commands and density choices
  typedef enum logic [CTRL_MOTION_W-1:0] {
    MOT_NONE, MOT_FWD, MOT_REV, MOT_SEARCH, MOT_REWIND, MOT_UNLOAD
  } tti_motion_t;
  localparam int MOTION_LINES = 5;

  localparam logic [CTRL_DENS_W-1:0] DENS_LOW  = 2'h1;
  localparam logic [CTRL_DENS_W-1:0] DENS_HIGH = 2'h2;

  // timing
  localparam int CLK_MHZ     = 100;
  localparam int WSTROBE_US  = 4;
  localparam int CLEAR_US    = 4;
  localparam int WSTROBE_CYC = WSTROBE_US * CLK_MHZ;
  localparam int CLEAR_CYC   = CLEAR_US * CLK_MHZ;
  localparam int PULSE_CNT_W = 16;

endpackage : tti_pkg

// >>> core/tti_pulse_if.sv
// Purpose: start and activity pair between the controller and a pulse timer
// Assumes: both ends on mclk_i
// Notes:   start is a one-cycle request, ignored while active is high
`timescale 1ns/1ps
interface tti_pulse_if;
  logic start;   // one-cycle request
  logic active;  // pulse level, from a register

  modport ctl (output start, input active);
  modport gen (input start, output active);
endinterface : tti_pulse_if

// >>> core/tti_sync.sv
// Purpose: two-flop synchroniser for a vector of pin inputs
// Assumes: each bit is an independent level or slow pulse
// Notes:   bits are not coherent with one another across the crossing
`timescale 1ns/1ps
module tti_sync
  import tti_pkg::*;
#(
  parameter int W = 1
) (
  input  wire logic         mclk_i,     // system clock
  input  wire logic         reset_n_i,  // async reset, active low
  input  wire logic [W-1:0] d_i,        // raw pin levels
  output logic      [W-1:0] q_o         // synchronised levels
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } tti_sync_state_t;

  tti_sync_state_t st_r;
  tti_sync_state_t st_nxt;

  // first stage feeds only the second stage
  always_comb begin
    st_nxt        = st_r;
    st_nxt.meta   = d_i;
    st_nxt.stable = st_r.meta;
  end

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign q_o = st_r.stable;

endmodule : tti_sync

// >>> core/tti_pulse_gen.sv
// Purpose: fixed-length pulse timer started by a one-cycle request
// Assumes: CYCLES fits in PULSE_CNT_W bits and is at least one
// Notes:   a start during an active pulse is dropped, not queued
`timescale 1ns/1ps
module tti_pulse_gen
  import tti_pkg::*;
#(
  parameter int CYCLES = WSTROBE_CYC
) (
  input  wire logic mclk_i,     // system clock
  input  wire logic reset_n_i,  // async reset, active low
  tti_pulse_if.gen  pls         // start in, active out
);

  localparam logic [PULSE_CNT_W-1:0] LAST = PULSE_CNT_W'(CYCLES - 1);

  typedef struct packed {
    logic                   active;
    logic [PULSE_CNT_W-1:0] cnt;
  } tti_pg_state_t;

  tti_pg_state_t st_r;
  tti_pg_state_t st_nxt;

  // active stays high for exactly CYCLES edges
  always_comb begin
    st_nxt = st_r;
    if (!st_r.active) begin
      if (pls.start) begin
        st_nxt.active = 1'b1;
        st_nxt.cnt    = '0;
      end
    end else if (st_r.cnt == LAST) begin
      st_nxt.active = 1'b0;
    end else begin
      st_nxt.cnt = st_r.cnt + 1'b1;
    end
  end

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign pls.active = st_r.active;

endmodule : tti_pulse_gen

// >>> dv/tti_tape_chk.sv
// Purpose: concurrent checks on the controller's cable outputs
// Assumes: one clock domain, mclk_i at 100 MHz
// Notes:   pulse lengths are counted in helper state, not unrolled
`timescale 1ns/1ps
module tti_tape_chk
  import tti_pkg::*;
(
  input wire logic              mclk_i, // system clock
  input wire logic              reset_n_i, // async reset, active low
  input wire logic [ADDR_W-1:0] reg_addr_i, // register address
  input wire logic [DATA_W-1:0] reg_wdata_i, // write data
  input wire logic              reg_we_i, // write strobe
  input wire logic [CHAR_W-1:0] write_char_o, // write character
  input wire logic              write_strobe_o, // character strobe
  input wire logic              fwd_o, // forward
  input wire logic              rev_o, // reverse
  input wire logic              search_o, // search
  input wire logic              rewind_o, // rewind
  input wire logic              unload_o, // rewind unload
  input wire logic              dens_high_o, // high density
  input wire logic              dens_low_o, // low density
  input wire logic              write_sel_o, // write select
  input wire logic              read_start_o, // read start
  input wire logic              initial_condition_clear_o // clear pulse
);
  typedef struct packed {
    logic [9:0] s;
    logic [9:0] c;
  } tti_cnt_t;
  tti_cnt_t   cnt_r;
  tti_cnt_t   cnt_nxt;
  wire  [4:0] mot = {fwd_o, rev_o, search_o, rewind_o, unload_o};

  // run lengths of both pulses, cleared when low
  always_comb begin
    cnt_nxt.s = write_strobe_o ? cnt_r.s + 10'h001 : 10'h000;
    cnt_nxt.c = initial_condition_clear_o ? cnt_r.c + 10'h001 : 10'h000;
  end
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) cnt_r <= '0;
    else cnt_r <= cnt_nxt;
  end

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!reset_n_i);

  a_strobe_len: assert property ($fell(write_strobe_o) |-> cnt_r.s == WSTROBE_CYC)
    else $error("write strobe length wrong");
  a_strobe_max: assert property (cnt_r.s <= WSTROBE_CYC)
    else $error("write strobe too long");
  a_strobe_cause: assert property ($rose(write_strobe_o)
    |-> $past(reg_we_i) && $past(reg_addr_i) == REG_WCHAR) else $error("strobe without write");
  a_char_value: assert property ($rose(write_strobe_o)
    |-> write_char_o == $past(reg_wdata_i[6:0])) else $error("write character wrong");
  a_char_hold: assert property (write_strobe_o && $past(write_strobe_o)
    |-> $stable(write_char_o)) else $error("character moved under strobe");
  a_one_motion: assert property ($onehot0(mot))
    else $error("two motion lines high");
  a_motion_gap: assert property (|(mot & ~$past(mot)) |-> $past(mot) == 5'h00)
    else $error("motion changed without a drop");
  a_clear_len: assert property ($fell(initial_condition_clear_o) |-> cnt_r.c == CLEAR_CYC)
    else $error("clear pulse length wrong");
  a_clear_quiet: assert property (initial_condition_clear_o
    |-> !(|mot || dens_high_o || dens_low_o || write_sel_o || read_start_o))
    else $error("select held during clear");
  a_dens_excl: assert property (!(dens_high_o && dens_low_o))
    else $error("both densities selected");
endmodule : tti_tape_chk

bind tti_tape_ctl tti_tape_chk i_chk (.*);

// >>> dv/tti_transport.sv
// Purpose: behavioural tape transport at the far end of the cable
// Assumes: times in ns; busy hold shortened
// Notes:   released read lines show the inverse of the last character
`timescale 1ns/1ps
module tti_transport #(
  parameter int BUSY_NS = 2000  // shortened busy hold after stop
) (
  input  wire logic [6:0] wchar_i,  // write character
  input  wire logic       wstb_i,   // write strobe
  input  wire logic [4:0] mot_i,    // fwd rev search rewind unload
  input  wire logic       dhi_i,    // high density select
  input  wire logic       dlo_i,    // low density select
  input  wire logic       wsel_i,   // write select
  input  wire logic       clr_i,    // initial condition clear
  output logic      [6:0] rchar_o,  // read character
  output logic            rstb_o,   // read strobe
  output logic      [7:0] unit_o,   // unit address lines
  output logic            busy_o,   // tape in motion
  output logic            d556_o,   // 556 lpi status
  output logic            fm_o,     // file mark
  output logic            lp_o,     // load point
  output logic            eor_o,    // end of record
  output logic            rdy_o     // ready
);
  logic [6:0] last_w = 7'h00;  // last recorded character
  int         idle   = 0;
  wire        moving = |mot_i && !clr_i && !eor_o;
  initial {rchar_o, rstb_o, unit_o, busy_o, d556_o, fm_o, lp_o, eor_o} = {7'h00, 1'b0, 8'h01, 5'h00};
  assign rdy_o = 1'b1;
  always @(negedge wstb_i) if (wsel_i) last_w = wchar_i;
  always @(posedge dhi_i) d556_o = 1'b1;
  always @(posedge dlo_i) d556_o = 1'b0;
  // busy polled every 100 ns
  always begin
    #100;
    if (moving) begin busy_o = 1'b1; idle = 0; end
    else if (idle < BUSY_NS / 100) idle++;
    else busy_o = 1'b0;
  end
  // search finds a mark, rewind a load point, after a short run
  always @(posedge mot_i[2] or posedge mot_i[1]) begin
    {fm_o, lp_o, eor_o} = 3'h0;
    #2000;
    if (mot_i[2]) fm_o = 1'b1;
    if (mot_i[1]) lp_o = 1'b1;
    eor_o = fm_o | lp_o;
  end
  task automatic set_unit(input logic [7:0] u); unit_o = u; endtask
  // read lines stable around one 160 ns strobe
  task automatic send(input logic [6:0] c);
    rchar_o = c; #80; rstb_o = 1'b1; #160; rstb_o = 1'b0; #80; rchar_o = ~c;
  endtask : send
endmodule : tti_transport

// >>> dv/testbench.sv
// Purpose: self-checking bench for the tape transport controller
// Assumes: 100 MHz mclk_i, register port one access per task
// Notes:   end of tape and write enable pins are tied
`timescale 1ns/1ps
module testbench;
  import tti_pkg::*;
  logic mclk_i = 1'b0, reset_n_i = 1'b0, reg_we_i = 1'b0, reg_re_i = 1'b0;
  logic [ADDR_W-1:0] reg_addr_i = '0;
  logic [DATA_W-1:0] reg_wdata_i = '0, d;
  logic end_of_tape_i = 1'b0, dens800_i = 1'b0, write_enable_i = 1'b1;
  wire [DATA_W-1:0] reg_rdata_o;
  wire [6:0] write_char_o, read_char_i;
  wire [7:0] unit_addr_i;
  wire write_strobe_o, fwd_o, rev_o, search_o, rewind_o, unload_o, dens_high_o, dens_low_o;
  wire write_sel_o, read_start_o, initial_condition_clear_o, lamp_connect_o, lamp_reserve_o;
  wire read_strobe_i, ready_i, busy_i, dens556_i, file_mark_i, load_point_i, end_of_record_i;
  wire [4:0] mot = {fwd_o, rev_o, search_o, rewind_o, unload_o};
  wire [5:0] sel = {dens_high_o, dens_low_o, write_sel_o, read_start_o, lamp_connect_o,
                    lamp_reserve_o};
  int n_fail = 0, n_tests = 0, n;

  always #5 mclk_i = ~mclk_i;
  tti_tape_ctl i_dut (.*);
  tti_transport i_tape (.wchar_i(write_char_o), .wstb_i(write_strobe_o), .mot_i(mot),
    .dhi_i(dens_high_o), .dlo_i(dens_low_o), .wsel_i(write_sel_o),
    .clr_i(initial_condition_clear_o), .rchar_o(read_char_i), .rstb_o(read_strobe_i),
    .unit_o(unit_addr_i), .busy_o(busy_i), .d556_o(dens556_i), .fm_o(file_mark_i),
    .lp_o(load_point_i), .eor_o(end_of_record_i), .rdy_o(ready_i));

  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    @(posedge mclk_i); reg_addr_i <= a; reg_wdata_i <= v; reg_we_i <= 1'b1;
    @(posedge mclk_i); reg_we_i <= 1'b0;
  endtask : wr
  // data taken the cycle it stands
  task automatic rd(input logic [7:0] a, output logic [15:0] v);
    @(posedge mclk_i); reg_addr_i <= a; reg_re_i <= 1'b1;
    @(posedge mclk_i); reg_re_i <= 1'b0;
    #1 v = reg_rdata_o;
  endtask : rd
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_tests++;
    if (g !== e) begin n_fail++; $display("mismatch %s expected %h seen %h", nm, e, g); end
  endtask : chk
  task automatic settle(); repeat (4) @(posedge mclk_i); #1; endtask : settle

  task automatic t_reset();
    rd(REG_CTRL, d); chk("ctrl reset", CTRL_RESET, d);
    rd(REG_STATUS, d); chk("status reset", 16'h1041, d);
    rd(8'h14, d); chk("unmapped", 16'h0000, d);
    $display("test reset done");
  endtask : t_reset
  // unit follows one line, holds over all-zero
  task automatic t_unit();
    i_tape.set_unit(8'h20); settle(); rd(REG_STATUS, d);
    chk("unit", 16'h0005, 16'(d[15:13]));
    i_tape.set_unit(8'h00); settle(); rd(REG_STATUS, d);
    chk("unit hold", 16'h0005, 16'(d[15:13]));
    i_tape.set_unit(8'h04); settle(); rd(REG_STATUS, d);
    chk("unit new", 16'h0002, 16'(d[15:13]));
    $display("test unit done");
  endtask : t_unit
  task automatic t_write();
    wr(REG_CTRL, 16'h0020); wr(REG_WCHAR, 16'h0055); wr(REG_WCHAR, 16'h002A);
    rd(REG_STATUS, d); chk("wr busy", 16'h0001, 16'(d[ST_WR_BUSY]));
    chk("wchar", 16'h0055, 16'(write_char_o));
    n = 0;
    while (write_strobe_o === 1'b1 && n < 1000) begin @(posedge mclk_i); #1; n++; end
    chk("strobe len", 16'(WSTROBE_CYC - 4), 16'(n));
    chk("recorded", 16'h0055, 16'(i_tape.last_w));
    wr(REG_WCHAR, 16'h002A); #1;
    chk("wchar next", 16'h002A, 16'(write_char_o));
    rd(REG_WCHAR, d); chk("wchar back", 16'h002A, d);
    repeat (WSTROBE_CYC) @(posedge mclk_i);
    chk("recorded next", 16'h002A, 16'(i_tape.last_w));
    $display("test write done");
  endtask : t_write
  // codes 1 to 7, back to back
  task automatic t_motion();
    for (int c = 1; c <= 7; c++) begin
      wr(REG_CTRL, 16'(c)); settle();
      chk("motion", 16'(5'h10 >> (c - 1)), 16'(mot));
    end
    wr(REG_CTRL, 16'h0000); repeat (250) @(posedge mclk_i);
    $display("test motion done");
  endtask : t_motion
  task automatic t_search();
    for (int k = 0; k < 2; k++) begin
      wr(REG_CTRL, k ? 16'h0004 : 16'h0003); settle(); n = 0;
      do begin rd(REG_STATUS, d); n++; end while (d[ST_END_REC] !== 1'b1 && n < 300);
      chk("mark", 16'h0001, 16'(d[k ? ST_LOAD_PT : ST_FILE_MARK]));
      chk("busy", 16'h0001, 16'(d[ST_BUSY]));
      n = 0;
      do begin rd(REG_STATUS, d); n++; end while (d[ST_BUSY] !== 1'b0 && n < 300);
      chk("stopped", 16'h0000, 16'(d[ST_BUSY]));
      wr(REG_CTRL, 16'h0000);
    end
    $display("test search done");
  endtask : t_search
  task automatic t_select();
    wr(REG_CTRL, 16'h01F0); settle();
    chk("selects", 16'h002F, 16'(sel));
    rd(REG_STATUS, d); chk("dens556", 16'h0001, 16'(d[ST_DENS556]));
    wr(REG_CTRL, 16'h0008); dens800_i <= 1'b1; settle();
    chk("low dens", 16'h0010, 16'(sel));
    rd(REG_STATUS, d); chk("dens200", 16'h0000, 16'(d[ST_DENS556]));
    chk("dens800", 16'h0001, 16'(d[ST_DENS800]));
    $display("test select done");
  endtask : t_select
  task automatic t_read();
    i_tape.send(7'h5A); rd(REG_STATUS, d);
    chk("rd valid", 16'h0001, 16'(d[ST_RD_VALID]));
    rd(REG_RCHAR, d); chk("rchar", 16'h005A, d);
    i_tape.send(7'h21); i_tape.send(7'h3C); rd(REG_STATUS, d);
    chk("overrun", 16'h0001, 16'(d[ST_OVERRUN]));
    rd(REG_RCHAR, d); chk("rchar last", 16'h003C, d);
    rd(REG_STATUS, d); chk("rd flags", 16'h0000, 16'(d[10:9]));
    $display("test read done");
  endtask : t_read
  // clear keeps lamps, refuses control writes
  task automatic t_clear();
    wr(REG_CTRL, 16'h01F1); settle(); wr(REG_CLEAR, 16'h0000); #1;
    chk("clear", 16'h0003, {14'h0, initial_condition_clear_o, lamp_connect_o});
    chk("cleared", 16'h0003, 16'({mot, sel}));
    wr(REG_CTRL, 16'h0000); n = 0;
    while (initial_condition_clear_o === 1'b1 && n < 1000) begin @(posedge mclk_i); #1; n++; end
    chk("lamps kept", 16'h0003, 16'(sel));
    wr(REG_CTRL, 16'h0000); settle(); chk("lamps off", 16'h0000, 16'(sel));
    $display("test clear done");
  endtask : t_clear

  task automatic print_verdict();
    $display("counts: %0d compared, %0d failed", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : print_verdict

  initial begin
    repeat (8) @(posedge mclk_i);
    reset_n_i <= 1'b1;
    t_reset(); t_unit(); t_write(); t_motion(); t_search(); t_select(); t_read(); t_clear();
    print_verdict();
  end
  // run needs roughly 25 us
  initial begin
    #500000; n_fail++; $display("watchdog expired"); print_verdict();
  end
endmodule : testbench
